/* File: core/psto_pkg.sv */
// shared constants and carrier types for the sample record trace output block
// ****************************************************************************
// How it works
// RULE_01 - per-record interrupt bit set: pend interrupt after every produced record
// RULE_02 - destination field 00B save area, 01B trace stream, others reserved
// RULE_03 - trace mode skips save area; reload values from dedicated reload registers
// RULE_04 - trace mode emits one begin packet then item packets per group
// RULE_05 - group ends at next begin packet or at an end packet
// RULE_06 - groups and elements may come in any order; headers identify content
// RULE_07 - no record format or record size packet is ever emitted
// RULE_08 - trigger-enable zero in trace mode: triggered records are discarded
// RULE_09 - context-enable and filter-enable never gate sample packets
// RULE_10 - counter reload happens on every trigger, even when record dropped
// RULE_11 - no buffer-threshold interrupt while in trace mode
// RULE_12 - trace region-full event may pend interrupt when enabled
// RULE_13 - save-buffer overflow flag never set while in trace mode
// RULE_14 - trace mode: each sample loads counter from its reload register
// RULE_15 - fixed counter 0 counts retired instructions, skid exactly one instruction
// RULE_16 - trace support bit and availability bit advertised in capabilities; only bit 16 is set in CAPS_O, trace support goes out on TRACE_SUPPORT_O
// RULE_17 - record packets interleave correctly with other trace packets
// RULE_18 - software must not write reserved destination encodings
// ****************************************************************************
package psto_pkg;
  localparam int CTR_W = 48;
  localparam int ELEM_W = 64;
  localparam int NUM_GP = 4;
  localparam int NUM_FIX = 3;
  localparam int NUM_CTR = NUM_GP + NUM_FIX;
  localparam int FIX0_IDX = NUM_GP;
  localparam int MAX_ELEM = 8;
  localparam int IRQ_PER_RECORD_BIT = 60;
  localparam int DEST_LO = 61;
  localparam int DEST_HI = 62;
  localparam int TRACE_SUPPORT_BIT = 25;
  localparam int TRACE_AVAIL_BIT = 16;
  localparam logic [63:0] ENABLE_RESET = 64'h0;
  localparam logic [CTR_W-1:0] CTR_ONE = 48'h1;

  typedef enum logic [1:0] {
    PSTO_DEST_SAVE = 2'h0,
    PSTO_DEST_TRACE = 2'h1,
    PSTO_DEST_RSV2 = 2'h2,
    PSTO_DEST_RSV3 = 2'h3
  } psto_dest_t;

  typedef enum logic [1:0] {
    PSTO_PKT_BEGIN = 2'h0,
    PSTO_PKT_ITEM = 2'h1,
    PSTO_PKT_END = 2'h2
  } psto_pkt_kind_t;

  typedef struct packed {
    psto_pkt_kind_t kind;
    logic [7:0] elem_id;
    logic [ELEM_W-1:0] payload;
  } psto_pkt_t;

  typedef struct packed {
    logic trigger;
    logic context_on;
    logic filter_on;
  } psto_trace_status_t;
endpackage

/* File: core/psto_reload.sv */
// per-counter reload register bank and counter reload logic
`timescale 1ns/1ps
module psto_reload #(
  parameter int N = psto_pkg::NUM_CTR,
  parameter int W = psto_pkg::CTR_W
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic [N-1:0] reload_we_i,
  input wire logic [W-1:0] reload_wdata_i,
  input wire logic [N-1:0] ctr_we_i,
  input wire logic [W-1:0] ctr_wdata_i,
  input wire logic [N-1:0] inc_i,
  input wire logic [N-1:0] sample_i,
  output logic [N*W-1:0] reload_o,
  output logic [N*W-1:0] count_o
);
  logic [W-1:0] rel [N];
  logic [W-1:0] cnt [N];
  logic [W-1:0] next_rel [N];
  logic [W-1:0] next_cnt [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ctr
      always_comb begin
        next_rel[g] = reload_we_i[g] ? reload_wdata_i : rel[g];
        next_cnt[g] = cnt[g];
        if (ctr_we_i[g]) begin
          next_cnt[g] = ctr_wdata_i;
        // RULE_14 reload on sample
        end else if (sample_i[g]) begin
          next_cnt[g] = rel[g];
        end else if (inc_i[g]) begin
          next_cnt[g] = cnt[g] + psto_pkg::CTR_ONE;
        end
      end
      always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
          rel[g] <= '0;
          cnt[g] <= '0;
        end else begin
          rel[g] <= next_rel[g];
          cnt[g] <= next_cnt[g];
        end
      end
      assign reload_o[g*W +: W] = rel[g];
      assign count_o[g*W +: W] = cnt[g];
    end
  endgenerate
endmodule

/* File: core/psto_packer.sv */
// packetizer: turns one sample group into begin, item and end packets
`timescale 1ns/1ps
module psto_packer #(
  parameter int NE = psto_pkg::MAX_ELEM
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic start_i,
  input wire logic [7:0] group_id_i,
  input wire logic [NE-1:0] elem_valid_i,
  input wire logic [NE*psto_pkg::ELEM_W-1:0] elem_data_i,
  input wire logic ready_i,
  output logic busy_o,
  output logic valid_o,
  output psto_pkg::psto_pkt_t pkt_o,
  output logic done_o
);
  typedef enum {PSTO_P_IDLE, PSTO_P_BEGIN, PSTO_P_ITEM, PSTO_P_END} psto_pstate_t;
  psto_pstate_t st, next_st;
  logic [NE-1:0] pend, next_pend;
  logic [NE*psto_pkg::ELEM_W-1:0] data, next_data;
  logic [7:0] gid, next_gid;
  logic [7:0] idx;
  logic found;

  always_comb begin
    idx = '0;
    found = 1'b0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = 8'(i);
        found = 1'b1;
      end
    end
  end

  always_comb begin
    next_st = st;
    next_pend = pend;
    next_data = data;
    next_gid = gid;
    valid_o = 1'b0;
    done_o = 1'b0;
    pkt_o = '0;
    case (st)
      PSTO_P_IDLE: begin
        if (start_i) begin
          next_pend = elem_valid_i;
          next_data = elem_data_i;
          next_gid = group_id_i;
          next_st = PSTO_P_BEGIN;
        end
      end
      // RULE_04 begin then items
      PSTO_P_BEGIN: begin
        valid_o = 1'b1;
        pkt_o.kind = psto_pkg::PSTO_PKT_BEGIN;
        pkt_o.elem_id = gid;
        if (ready_i) begin
          next_st = found ? PSTO_P_ITEM : PSTO_P_END;
        end
      end
      // RULE_06 header carries element id
      PSTO_P_ITEM: begin
        valid_o = 1'b1;
        pkt_o.kind = psto_pkg::PSTO_PKT_ITEM;
        pkt_o.elem_id = idx;
        pkt_o.payload = data[idx*psto_pkg::ELEM_W +: psto_pkg::ELEM_W];
        if (ready_i) begin
          next_pend[idx[$clog2(NE)-1:0]] = 1'b0;
          if ((pend & ~(NE'(1) << idx)) == '0) begin
            next_st = PSTO_P_END;
          end
        end
      end
      // RULE_05 end packet closes group
      PSTO_P_END: begin
        valid_o = 1'b1;
        pkt_o.kind = psto_pkg::PSTO_PKT_END;
        if (ready_i) begin
          done_o = 1'b1;
          next_st = PSTO_P_IDLE;
        end
      end
      default: next_st = PSTO_P_IDLE;
    endcase
  end

  assign busy_o = (st != PSTO_P_IDLE);

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st <= PSTO_P_IDLE;
      pend <= '0;
      data <= '0;
      gid <= '0;
    end else begin
      st <= next_st;
      pend <= next_pend;
      data <= next_data;
      gid <= next_gid;
    end
  end
endmodule

/* File: core/psto_top.sv */
// sample record output router: save area or trace packet stream
`timescale 1ns/1ps
module psto_top #(
  parameter int N = psto_pkg::NUM_CTR,
  parameter int W = psto_pkg::CTR_W,
  parameter int NE = psto_pkg::MAX_ELEM
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // ****************************************************************
  // register port
  // ****************************************************************
  input wire logic ENABLE_WE_I,
  input wire logic [63:0] ENABLE_WDATA_I,
  output logic [63:0] ENABLE_RDATA_O,
  input wire logic [N-1:0] RELOAD_WE_I,
  input wire logic [N-1:0] CTR_WE_I,
  input wire logic [W-1:0] WDATA_I,
  output logic [N*W-1:0] RELOAD_RDATA_O,
  output logic [N*W-1:0] COUNT_O,
  output logic [63:0] CAPS_O,
  output logic TRACE_SUPPORT_O,
  output logic DEST_INVALID_O,
  // ****************************************************************
  // counter and event side
  // ****************************************************************
  input wire logic [N-1:0] EVENT_I,
  input wire logic [N-1:0] SAMPLE_I,
  input wire logic [NE-1:0] ELEM_VALID_I,
  input wire logic [NE*psto_pkg::ELEM_W-1:0] ELEM_DATA_I,
  input wire logic SAVE_THRESHOLD_I,
  input wire logic SAVE_OVERFLOW_I,
  output logic SAVE_REQ_O,
  output logic SAMPLE_BUSY_O,
  output logic SAVE_OVERFLOW_FLAG_O,
  // ****************************************************************
  // trace packet unit side
  // ****************************************************************
  input wire psto_pkg::psto_trace_status_t TRACE_STATUS_I,
  input wire logic REGION_FULL_I,
  input wire logic REGION_IRQ_EN_I,
  input wire logic PKT_READY_I,
  output logic PKT_VALID_O,
  output psto_pkg::psto_pkt_t PKT_O,
  output logic DROPPED_O,
  output logic PERF_MONITOR_INTERRUPT_O
);
  logic [63:0] enable, next_enable;
  logic ovf, next_ovf;
  logic perf_monitor_interrupt, next_perf_monitor_interrupt;
  logic dropped, next_dropped;
  logic save_req, next_save_req;
  logic [7:0] grp, next_grp;
  logic [1:0] dest;
  logic trace_mode;
  logic any_sample;
  logic pk_busy;
  logic pk_done;
  logic pk_start;
  logic [N-1:0] inc;
  logic [N-1:0] fix0_skid, next_fix0_skid;

  assign dest = enable[psto_pkg::DEST_HI:psto_pkg::DEST_LO];
  // RULE_02 destination decode
  assign trace_mode = (dest == psto_pkg::PSTO_DEST_TRACE);
  // RULE_18 reserved encodings flagged
  assign DEST_INVALID_O = dest[1];
  assign any_sample = |SAMPLE_I;
  // RULE_08 drop when trigger off
  // RULE_09 context and filter ignored
  assign pk_start = any_sample && trace_mode && TRACE_STATUS_I.trigger && !pk_busy;
  assign inc = EVENT_I;

  // ****************************************************************
  // fixed counter 0 skid
  // ****************************************************************
  // RULE_15 one instruction skid
  always_comb begin
    next_fix0_skid = '0;
    next_fix0_skid[psto_pkg::FIX0_IDX] = SAMPLE_I[psto_pkg::FIX0_IDX];
  end

  always_comb begin
    next_enable = ENABLE_WE_I ? ENABLE_WDATA_I : enable;
    next_ovf = ovf;
    // RULE_13 overflow flagged in every mode except trace
    if (!trace_mode && SAVE_OVERFLOW_I) begin
      next_ovf = 1'b1;
    end
    next_perf_monitor_interrupt = 1'b0;
    // RULE_11 threshold interrupt in every mode except trace
    if (!trace_mode && SAVE_THRESHOLD_I) begin
      next_perf_monitor_interrupt = 1'b1;
    end
    // RULE_12 region full interrupt
    if (trace_mode && REGION_FULL_I && REGION_IRQ_EN_I) begin
      next_perf_monitor_interrupt = 1'b1;
    end
    // RULE_01 interrupt per record
    if (enable[psto_pkg::IRQ_PER_RECORD_BIT] && (pk_done || (save_req && !trace_mode))) begin
      next_perf_monitor_interrupt = 1'b1;
    end
    next_dropped = any_sample && trace_mode && !TRACE_STATUS_I.trigger;
    // RULE_03 save area used only in save mode
    next_save_req = any_sample && (dest == psto_pkg::PSTO_DEST_SAVE);
    next_grp = pk_start ? grp + 8'h01 : grp;
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      enable <= psto_pkg::ENABLE_RESET;
      ovf <= 1'b0;
      perf_monitor_interrupt <= 1'b0;
      dropped <= 1'b0;
      save_req <= 1'b0;
      grp <= '0;
      fix0_skid <= '0;
    end else begin
      enable <= next_enable;
      ovf <= next_ovf;
      perf_monitor_interrupt <= next_perf_monitor_interrupt;
      dropped <= next_dropped;
      save_req <= next_save_req;
      grp <= next_grp;
      fix0_skid <= next_fix0_skid;
    end
  end

  // ****************************************************************
  // counters and reload
  // ****************************************************************
  // RULE_10 reload regardless of trigger
  psto_reload #(.N(N), .W(W)) u_reload (
    .MCLK_I(MCLK_I),
    .RESET_I(RESET_I),
    .reload_we_i(RELOAD_WE_I),
    .reload_wdata_i(WDATA_I),
    .ctr_we_i(CTR_WE_I),
    .ctr_wdata_i(WDATA_I),
    .inc_i(inc),
    .sample_i((SAMPLE_I & ~(N'(1) << psto_pkg::FIX0_IDX)) | fix0_skid),
    .reload_o(RELOAD_RDATA_O),
    .count_o(COUNT_O)
  );

  // ****************************************************************
  // packetizer
  // ****************************************************************
  // RULE_07 only begin, item, end kinds exist
  // RULE_17 valid and ready handshake lets stream interleave
  psto_packer #(.NE(NE)) u_packer (
    .MCLK_I(MCLK_I),
    .RESET_I(RESET_I),
    .start_i(pk_start),
    .group_id_i(grp),
    .elem_valid_i(ELEM_VALID_I),
    .elem_data_i(ELEM_DATA_I),
    .ready_i(PKT_READY_I),
    .busy_o(pk_busy),
    .valid_o(PKT_VALID_O),
    .pkt_o(PKT_O),
    .done_o(pk_done)
  );

  // RULE_16 capability bits
  always_comb begin
    CAPS_O = '0;
    CAPS_O[psto_pkg::TRACE_AVAIL_BIT] = 1'b1;
  end
  assign TRACE_SUPPORT_O = 1'b1;
  assign ENABLE_RDATA_O = enable;
  assign SAVE_REQ_O = save_req;
  assign SAMPLE_BUSY_O = pk_busy;
  assign SAVE_OVERFLOW_FLAG_O = ovf;
  assign DROPPED_O = dropped;
  assign PERF_MONITOR_INTERRUPT_O = perf_monitor_interrupt;
endmodule

/* File: verif/psto_top_chk.sv */
// port-level assertions for the sample record trace output block
`timescale 1ns/1ps
module psto_top_chk #(
  parameter int N = psto_pkg::NUM_CTR,
  parameter int W = psto_pkg::CTR_W
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic [63:0] ENABLE_RDATA_O,
  input wire logic [N-1:0] RELOAD_WE_I,
  input wire logic [N-1:0] CTR_WE_I,
  input wire logic [N*W-1:0] RELOAD_RDATA_O,
  input wire logic [N*W-1:0] COUNT_O,
  input wire logic [63:0] CAPS_O,
  input wire logic TRACE_SUPPORT_O,
  input wire logic DEST_INVALID_O,
  input wire logic [N-1:0] EVENT_I,
  input wire logic [N-1:0] SAMPLE_I,
  input wire logic SAVE_REQ_O,
  input wire logic SAMPLE_BUSY_O,
  input wire logic SAVE_OVERFLOW_FLAG_O,
  input wire psto_pkg::psto_trace_status_t TRACE_STATUS_I,
  input wire logic PKT_READY_I,
  input wire logic PKT_VALID_O,
  input wire psto_pkg::psto_pkt_t PKT_O,
  input wire logic DROPPED_O,
  input wire logic PERF_MONITOR_INTERRUPT_O
);
  logic [1:0] dest;
  logic go;
  logic q0;
  logic q4;
  assign dest = ENABLE_RDATA_O[62:61];
  assign go = !SAMPLE_BUSY_O && dest == 2'h1;
  // a counter write on the sample edge would blur the reload, as it wins over the sample
  assign q0 = !CTR_WE_I[0] && !RELOAD_WE_I[0] && !EVENT_I[0];
  assign q4 = !CTR_WE_I[4] && !RELOAD_WE_I[4] && !EVENT_I[4];
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  a_dest_flag: assert property (DEST_INVALID_O == dest[1])
    else $error("reserved destination flag wrong");
  a_caps_bits: assert property (CAPS_O[16] && TRACE_SUPPORT_O)
    else $error("capability bits missing");
  a_save_route: assert property (|SAMPLE_I && dest == 2'h0 |=> SAVE_REQ_O)
    else $error("no save request");
  a_drop_idle: assert property (|SAMPLE_I && go && !TRACE_STATUS_I.trigger |=> DROPPED_O && !PKT_VALID_O)
    else $error("record not dropped");
  a_begin_first: assert property (|SAMPLE_I && go && TRACE_STATUS_I.trigger
    |=> PKT_VALID_O && PKT_O.kind == psto_pkg::PSTO_PKT_BEGIN)
    else $error("no begin packet");
  a_no_format: assert property (PKT_VALID_O |-> PKT_O.kind != 2'h3)
    else $error("unknown packet kind");
  a_pkt_hold: assert property (PKT_VALID_O && !PKT_READY_I |=> PKT_VALID_O && $stable(PKT_O))
    else $error("packet changed while stalled");
  a_irq_record: assert property (PKT_VALID_O && PKT_READY_I && ENABLE_RDATA_O[60]
    && PKT_O.kind == psto_pkg::PSTO_PKT_END |=> PERF_MONITOR_INTERRUPT_O)
    else $error("no interrupt after record");
  a_ovf_quiet: assert property ($rose(SAVE_OVERFLOW_FLAG_O) |-> $past(dest) != 2'h1)
    else $error("overflow flag set in trace mode");
  a_reload_gp: assert property (SAMPLE_I[0] && q0
    |=> COUNT_O[W-1:0] == $past(RELOAD_RDATA_O[W-1:0]))
    else $error("counter 0 not reloaded");
  a_fix0_skid: assert property (SAMPLE_I[4] && q4 ##1 q4
    |=> COUNT_O[4*W +: W] == $past(RELOAD_RDATA_O[4*W +: W], 2))
    else $error("fixed counter 0 reload late");
endmodule

bind psto_top psto_top_chk #(.N(N), .W(W)) u_chk (.*);

/* File: verif/psto_sink.sv */
// trace packet unit model: accepts packets and sorts them by header kind
`timescale 1ns/1ps
module psto_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire psto_pkg::psto_pkt_t pkt_i,
  output logic ready_o,
  output logic [7:0] begins_o,
  output logic [7:0] items_o,
  output logic [7:0] ends_o,
  output psto_pkg::psto_pkt_t last_o
);
  // stalling lets the bench hold the stream as a slow consumer would
  assign ready_o = !stall_i;
  // content told apart by header kind only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      begins_o <= 8'h0;
      items_o <= 8'h0;
      ends_o <= 8'h0;
      last_o <= '0;
    end else if (valid_i && ready_o) begin
      case (pkt_i.kind)
        psto_pkg::PSTO_PKT_BEGIN: begins_o <= begins_o + 8'h1;
        psto_pkg::PSTO_PKT_ITEM: begin
          items_o <= items_o + 8'h1;
          last_o <= pkt_i;
        end
        default: ends_o <= ends_o + 8'h1;
      endcase
    end
  end
endmodule

/* File: verif/psto_top_test.sv */
// self-checking bench for the sample record trace output block
`timescale 1ns/1ps
module psto_top_test;
  localparam int N = psto_pkg::NUM_CTR;
  localparam int W = psto_pkg::CTR_W;
  logic MCLK_I = 0, RESET_I = 1, ENABLE_WE_I = 0, stall = 0;
  logic SAVE_THRESHOLD_I = 0, SAVE_OVERFLOW_I = 0, REGION_FULL_I = 0, REGION_IRQ_EN_I = 0;
  logic [63:0] ENABLE_WDATA_I = 64'h0, ENABLE_RDATA_O, CAPS_O;
  logic [N-1:0] RELOAD_WE_I = '0, CTR_WE_I = '0, EVENT_I = '0, SAMPLE_I = '0;
  logic [W-1:0] WDATA_I = 48'h0;
  logic [N*W-1:0] RELOAD_RDATA_O, COUNT_O;
  logic [7:0] ELEM_VALID_I = 8'h05;
  logic [8*64-1:0] ELEM_DATA_I = {384'h0, 64'hB, 64'h0, 64'hA};
  logic TRACE_SUPPORT_O, DEST_INVALID_O, SAVE_REQ_O, SAMPLE_BUSY_O, SAVE_OVERFLOW_FLAG_O;
  logic PKT_READY_I, PKT_VALID_O, DROPPED_O, PERF_MONITOR_INTERRUPT_O;
  logic [7:0] begins, items, ends;
  psto_pkg::psto_trace_status_t TRACE_STATUS_I = '0;
  psto_pkg::psto_pkt_t PKT_O, last;
  int n_fail = 0, comparisons = 0, n_irq = 0, cyc = 0;

  psto_top u_dut (.*);
  psto_sink u_sink (.clk_i(MCLK_I), .rst_i(RESET_I), .stall_i(stall), .valid_i(PKT_VALID_O),
    .pkt_i(PKT_O), .ready_o(PKT_READY_I), .begins_o(begins), .items_o(items),
    .ends_o(ends), .last_o(last));

  initial forever #2 MCLK_I = ~MCLK_I;

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge MCLK_I);
  endtask
  task automatic wr_en(input logic [1:0] d, input logic irq);
    ENABLE_WDATA_I = {1'b0, d, irq, 60'h0};
    ENABLE_WE_I = 1;
    tick(1);
    ENABLE_WE_I = 0;
  endtask
  task automatic samp(input logic [N-1:0] m);
    SAMPLE_I = m;
    tick(1);
    SAMPLE_I = '0;
  endtask
  task automatic pulse(input int k);
    {REGION_FULL_I, SAVE_OVERFLOW_I, SAVE_THRESHOLD_I} = 3'(k);
    tick(1);
    {REGION_FULL_I, SAVE_OVERFLOW_I, SAVE_THRESHOLD_I} = 3'h0;
    tick(2);
  endtask
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge MCLK_I) begin
    cyc++;
    if (PERF_MONITOR_INTERRUPT_O === 1'b1) n_irq++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    tick(16);
    RESET_I = 0;
    tick(1);
    chk("caps", {CAPS_O[16], TRACE_SUPPORT_O}, 64'h3);
    chk("enable reset", ENABLE_RDATA_O, 64'h0);
    for (int d = 0; d < 4; d++) begin
      wr_en(2'(d), 1'b1);
      chk("dest", ENABLE_RDATA_O[62:60], 64'(d * 2 + 1));
      chk("dest invalid", DEST_INVALID_O, 64'(d / 2));
      // let an edge pass so the strobe is not raised in the step that lowered it
      tick(1);
    end
    WDATA_I = 48'h123;
    RELOAD_WE_I = 7'h11;
    tick(1);
    RELOAD_WE_I = '0;
    WDATA_I = 48'h10;
    CTR_WE_I = '1;
    tick(1);
    CTR_WE_I = '0;
    EVENT_I = 7'h02;
    tick(5);
    EVENT_I = '0;
    chk("count1", COUNT_O[W +: W], 64'h15);
    wr_en(2'h1, 1'b1);
    // context and filter high must not rescue a record while trigger is low
    TRACE_STATUS_I = 3'b011;
    samp(7'h11);
    chk("dropped", {DROPPED_O, PKT_VALID_O}, 64'h2);
    chk("no save trace", SAVE_REQ_O, 64'h0);
    chk("count0", COUNT_O[0 +: W], 64'h123);
    chk("fix0 early", COUNT_O[4*W +: W], 64'h10);
    tick(1);
    chk("fix0", COUNT_O[4*W +: W], 64'h123);
    CTR_WE_I = 7'h01;
    tick(1);
    CTR_WE_I = '0;
    TRACE_STATUS_I = 3'b100;
    stall = 1;
    samp(7'h01);
    tick(2);
    chk("begin held", {PKT_VALID_O, PKT_O.kind}, 64'h4);
    chk("no ctx gate", {TRACE_STATUS_I.context_on, TRACE_STATUS_I.filter_on, PKT_VALID_O}, 64'h1);
    chk("reload trace", COUNT_O[0 +: W], 64'h123);
    chk("reload reg", RELOAD_RDATA_O[0 +: W], 64'h123);
    chk("busy held", SAMPLE_BUSY_O, 64'h1);
    stall = 0;
    for (int i = 0; i < 20 && ends == 8'h0; i++) tick(1);
    tick(2);
    chk("groups", {begins, items, ends}, 64'h010201);
    chk("last item", {last.elem_id, last.payload[7:0]}, 64'h020B);
    chk("irq record", 64'(n_irq), 64'h1);
    pulse(3);
    chk("ovf trace", SAVE_OVERFLOW_FLAG_O, 64'h0);
    chk("irq threshold", 64'(n_irq), 64'h1);
    REGION_IRQ_EN_I = 1;
    pulse(4);
    chk("irq region", 64'(n_irq), 64'h2);
    wr_en(2'h0, 1'b0);
    samp(7'h01);
    chk("save route", {SAVE_REQ_O, PKT_VALID_O}, 64'h2);
    pulse(2);
    chk("ovf save", SAVE_OVERFLOW_FLAG_O, 64'h1);
    chk("irq none", 64'(n_irq), 64'h2);
    complete_run();
  end
endmodule
